// File: shared/tbtc_pkg.sv
/*
  tbtc_pkg: register map, field positions, reset values and timing
  constants of the 10BASE-T control and driver test register pair.
  assumes a 25 MHz core clock and a 32-bit APB register bus.
*/
package tbtc_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] TBTC_IDX_STS_CTRL = 8'h1A;
  localparam logic [7:0] TBTC_IDX_TEST_EXT = 8'h1B;
  localparam logic [11:0] TBTC_ADDR_STS_CTRL = {2'h0, TBTC_IDX_STS_CTRL, 2'h0};
  localparam logic [11:0] TBTC_ADDR_TEST_EXT = {2'h0, TBTC_IDX_TEST_EXT, 2'h0};
  localparam int TBTC_REG_W = 16;

  // ****************************************************************
  // ten_mb_status_control fields
  // ****************************************************************
  localparam int TBTC_B_RSV_TOP = 15;
  localparam int TBTC_B_RSV_HI = 14;
  localparam int TBTC_B_RSV_LO = 12;
  localparam int TBTC_B_SQ_HI = 11;
  localparam int TBTC_B_SQ_LO = 9;
  localparam int TBTC_B_LOOP_DIS = 8;
  localparam int TBTC_B_LINK_PULSE_DISABLE = 7;
  localparam int TBTC_B_LINK_FRC = 6;
  localparam int TBTC_B_POL_FRC = 5;
  localparam int TBTC_B_POL_STS = 4;
  localparam int TBTC_B_APOL_DIS = 3;
  localparam int TBTC_B_SIL_MSB = 2;
  localparam int TBTC_B_HB_DIS = 1;
  localparam int TBTC_B_JAB_DIS = 0;
  localparam logic [2:0] TBTC_RST_RSV = 3'h0;
  localparam logic [2:0] TBTC_RST_SQ = 3'h4;
  localparam logic TBTC_RST_SIL_MSB = 1'b1;

  // ****************************************************************
  // driver_test_bist_ext fields
  // ****************************************************************
  localparam int TBTC_B_ERR_HI = 15;
  localparam int TBTC_B_ERR_LO = 8;
  localparam int TBTC_B_RSV7 = 7;
  localparam int TBTC_B_MII_CLK = 6;
  localparam int TBTC_B_CONT = 5;
  localparam int TBTC_B_PAT_EN = 4;
  localparam int TBTC_B_PULLUP = 3;
  localparam int TBTC_B_GAP = 2;
  localparam int TBTC_B_PSEL_HI = 1;
  localparam int TBTC_B_PSEL_LO = 0;
  localparam logic [7:0] TBTC_ERR_MAX = 8'hFF;
  localparam logic [7:0] TBTC_ERR_RST = 8'h00;

  // ****************************************************************
  // pattern select and gap timing
  // ****************************************************************
  typedef enum logic [1:0] {
    TBTC_PAT_DATA_EOP0 = 2'h0,
    TBTC_PAT_DATA_EOP1 = 2'h1,
    TBTC_PAT_LINK_PULSE = 2'h2,
    TBTC_PAT_MANCH_ONES = 2'h3
  } tbtc_pat_t;
  localparam int TBTC_CLK_MHZ = 25;
  localparam int TBTC_GAP_SHORT_US = 10;
  localparam int TBTC_GAP_LONG_US = 15;
  localparam int TBTC_GAP_W = 9;
  localparam logic [TBTC_GAP_W-1:0] TBTC_GAP_SHORT_CYC = TBTC_GAP_W'(TBTC_GAP_SHORT_US * TBTC_CLK_MHZ);
  localparam logic [TBTC_GAP_W-1:0] TBTC_GAP_LONG_CYC = TBTC_GAP_W'(TBTC_GAP_LONG_US * TBTC_CLK_MHZ);
  localparam logic [TBTC_GAP_W-1:0] TBTC_GAP_ONE = 9'h001;

endpackage

// File: shared/tbtc_test_if.sv
/*
  tbtc_test_if: carries pattern generator and self test counter
  signals between the register bank and its two helpers.
  assumes all parties run on the same clock.
*/
`timescale 1ns/10ps
interface tbtc_test_if;
  import tbtc_pkg::*;
  logic pat_en;
  logic gap_long;
  logic [1:0] pat_sel;
  logic seq_start;
  logic seq_done;
  logic seq_busy;
  logic restart;
  logic nibble_err;
  logic [7:0] err_count;
  modport bank (output pat_en, output gap_long, output pat_sel, output seq_done, output restart,
                output nibble_err, input seq_start, input seq_busy, input err_count);
  modport patt (input pat_en, input gap_long, input pat_sel, input seq_done, output seq_start,
                output seq_busy);
  modport errc (input restart, input nibble_err, output err_count);
endinterface

// File: verification/tbtc_regs_chk.sv
/*
  tbtc_regs_chk: port level assertions for tbtc_regs.
  assumes one clock domain and a zero wait state APB slave.
*/
`timescale 1ns/10ps
module tbtc_regs_chk
  import tbtc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // status inputs
  input wire logic basic_ctrl_loopback,
  input wire logic mac_side_link_force,
  input wire logic speed_100,
  input wire logic pol_invert_detect,
  input wire logic phy_status_read,
  // controls
  input wire logic [2:0] squelch_sel,
  input wire logic ten_mb_loop_disable,
  input wire logic link_good_forced,
  input wire logic polarity_status,
  input wire logic jabber_en,
  input wire logic driver_pattern_enable,
  input wire logic [1:0] driver_pattern_select,
  input wire logic driver_seq_busy
);
  // ****************************************
  // helpers and assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic acc;
  logic wr_sts;
  logic [9:0] idle_ff;
  assign acc = psel && penable;
  assign wr_sts = acc && pwrite && paddr == TBTC_ADDR_STS_CTRL && pstrb[1];
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idle_ff <= 10'h000;
    end else if (!driver_pattern_enable || driver_seq_busy) begin
      idle_ff <= 10'h000;
    end else begin
      idle_ff <= idle_ff + 10'h001;
    end
  end
  property p_sq; wr_sts |=> squelch_sel == $past(pwdata[11:9]); endproperty
  a_sq: assert property (p_sq) else $error("squelch field not loaded");
  property p_loop; wr_sts |=> ten_mb_loop_disable == ($past(pwdata[8]) | basic_ctrl_loopback); endproperty
  a_loop: assert property (p_loop) else $error("loop disable wrong");
  property p_top; acc && !pwrite && paddr == TBTC_ADDR_STS_CTRL |-> prdata[31:15] == 17'h00000; endproperty
  a_top: assert property (p_top) else $error("top bits not zero");
  property p_unm; acc && !pwrite && paddr != TBTC_ADDR_STS_CTRL && paddr != TBTC_ADDR_TEST_EXT
    |-> pslverr && prdata == 32'h00000000; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not refused");
  property p_rdy; acc |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("access not answered");
  property p_pset; $rose(polarity_status) |-> $past(pol_invert_detect); endproperty
  a_pset: assert property (p_pset) else $error("polarity latch set without cause");
  property p_pclr; phy_status_read && !pol_invert_detect |=> !polarity_status; endproperty
  a_pclr: assert property (p_pclr) else $error("polarity latch not cleared");
  property p_jab; speed_100 |-> jabber_en; endproperty
  a_jab: assert property (p_jab) else $error("jabber disabled at 100 Mb");
  property p_link; mac_side_link_force [*3] |-> link_good_forced; endproperty
  a_link: assert property (p_link) else $error("mac link force ignored");
  property p_sel; !driver_pattern_enable |-> driver_pattern_select == 2'h0; endproperty
  a_sel: assert property (p_sel) else $error("pattern select while off");
  property p_gap; $rose(driver_seq_busy) |-> idle_ff <= 10'h002 || idle_ff == TBTC_GAP_SHORT_CYC
    || idle_ff == TBTC_GAP_LONG_CYC; endproperty
  a_gap: assert property (p_gap) else $error("test sequence gap wrong");
endmodule
bind tbtc_regs tbtc_regs_chk u_chk (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
  .pready, .pslverr, .basic_ctrl_loopback, .mac_side_link_force, .speed_100, .pol_invert_detect,
  .phy_status_read, .squelch_sel, .ten_mb_loop_disable, .link_good_forced, .polarity_status, .jabber_en,
  .driver_pattern_enable, .driver_pattern_select, .driver_seq_busy);

// File: verification/tbtc_regs_tb_top.sv
/*
  tbtc_regs_tb_top: self-checking bench of the register pair over APB.
  assumes a 25 MHz clock and the transmitter model for sequence ends.
*/
`timescale 1ns/10ps
module tbtc_regs_tb_top;
  import tbtc_pkg::*;
  logic clk, nrst, soft_rst, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pstrb;
  logic basic_ctrl_loopback, mac_side_link_force, speed_100, full_duplex, signal_detect_config;
  logic pol_invert_detect, phy_status_read, selftest_active, selftest_restart, selftest_nibble_err;
  logic test_seq_done, ten_mb_loop_disable, link_pulse_tx_en, link_good_forced, force_inverted_pol;
  logic auto_pol_correct_en, polarity_status, heartbeat_en, jabber_en, mii_clk_force, selftest_continuous;
  logic driver_pattern_enable, driver_seq_start, driver_seq_busy, mgmt_data_pullup_en;
  logic [2:0] squelch_sel;
  logic [1:0] silence_thresh_sel, driver_pattern_select;
  int n_mismatch, n_tests, n;
  localparam logic [11:0] STS = TBTC_ADDR_STS_CTRL;
  localparam logic [11:0] TST = TBTC_ADDR_TEST_EXT;
  tbtc_regs u_dut (.clk, .nrst, .soft_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .basic_ctrl_loopback, .mac_side_link_force, .speed_100, .full_duplex, .signal_detect_config,
    .pol_invert_detect, .phy_status_read, .selftest_active, .selftest_restart, .selftest_nibble_err,
    .test_seq_done, .squelch_sel, .ten_mb_loop_disable, .link_pulse_tx_en, .link_good_forced,
    .force_inverted_pol, .auto_pol_correct_en, .polarity_status, .silence_thresh_sel, .heartbeat_en,
    .jabber_en, .mii_clk_force, .selftest_continuous, .driver_pattern_enable, .driver_pattern_select,
    .driver_seq_start, .driver_seq_busy, .mgmt_data_pullup_en);
  tbtc_tx_model u_tx (.clk, .nrst, .driver_seq_start, .test_seq_done);
  // ****************************************
  // bus and check tasks
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task tick(input int c);
    repeat (c) @(posedge clk);
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    tick(1);
    penable <= 1'b1;
    tick(1);
    while (pready !== 1'b1) begin
      tick(1);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    tick(1);
  endtask
  task rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(nm, rdat, exp);
  endtask
  task wait_busy(input logic v);
    n = 0;
    while (driver_seq_busy !== v && n < 100) begin
      n++;
      tick(1);
    end
    if (n == 100) begin
      n_mismatch++;
    end
  endtask
  task wrap_up;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_defaults;
    rd("sts rst", STS, 32'h00000804);
    rd("test rst", TST, 32'h00000000);
    chk("rst outs", {squelch_sel, link_pulse_tx_en, auto_pol_correct_en, heartbeat_en, jabber_en}, 32'h4F);
  endtask
  task t_ctrl;
    signal_detect_config <= 1'b1;
    apb(1'b1, STS, 32'h00008FEF);
    rd("sts wr", STS, 32'h00000FEF);
    chk("ctrl", {squelch_sel, ten_mb_loop_disable, link_pulse_tx_en, link_good_forced, force_inverted_pol,
      auto_pol_correct_en, heartbeat_en, jabber_en}, 32'h3D8);
    chk("silence", silence_thresh_sel, 32'h3);
    speed_100 <= 1'b1;
    tick(1);
    chk("100mb", {force_inverted_pol, heartbeat_en, jabber_en}, 32'h1);
    speed_100 <= 1'b0;
    apb(1'b1, STS, 32'h00000800);
    chk("hb half", heartbeat_en, 32'h1);
    full_duplex <= 1'b1;
    basic_ctrl_loopback <= 1'b1;
    mac_side_link_force <= 1'b1;
    tick(3);
    chk("or inputs", {heartbeat_en, ten_mb_loop_disable, link_good_forced}, 32'h3);
    full_duplex <= 1'b0;
    basic_ctrl_loopback <= 1'b0;
    mac_side_link_force <= 1'b0;
  endtask
  task t_pol;
    pol_invert_detect <= 1'b1;
    tick(1);
    pol_invert_detect <= 1'b0;
    tick(1);
    rd("pol set", STS, 32'h00000810);
    rd("pol rdclr", STS, 32'h00000800);
    pol_invert_detect <= 1'b1;
    tick(1);
    pol_invert_detect <= 1'b0;
    phy_status_read <= 1'b1;
    tick(1);
    phy_status_read <= 1'b0;
    tick(1);
    chk("pol phy_status_reg", polarity_status, 32'h0);
  endtask
  task t_err;
    selftest_nibble_err <= 1'b1;
    tick(3);
    selftest_nibble_err <= 1'b0;
    rd("err 3", TST, 32'h00000300);
    selftest_nibble_err <= 1'b1;
    tick(300);
    selftest_nibble_err <= 1'b0;
    rd("err max", TST, 32'h0000FF00);
    selftest_restart <= 1'b1;
    tick(1);
    selftest_restart <= 1'b0;
    rd("err clr", TST, 32'h00000000);
  endtask
  task t_test;
    apb(1'b1, STS, 32'h00000801);
    chk("jab off", jabber_en, 32'h0);
    selftest_active <= 1'b1;
    apb(1'b1, TST, 32'h0000FF7F);
    rd("test wr", TST, 32'h0000007F);
    chk("test outs", {mii_clk_force, selftest_continuous, driver_pattern_enable, driver_pattern_select,
      mgmt_data_pullup_en}, 32'h3F);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, TST, 32'h00000010 | i);
      chk("pat sel", driver_pattern_select, i);
    end
    apb(1'b1, TST, 32'h00000003);
    chk("pat off", {driver_pattern_enable, driver_pattern_select}, 32'h0);
    for (int g = 0; g < 2; g++) begin
      apb(1'b1, TST, 32'h00000010 | (g << 2));
      wait_busy(1'b1);
      wait_busy(1'b0);
      n = 0;
      while (driver_seq_busy === 1'b0 && n < 1000) begin
        n++;
        tick(1);
      end
      chk("gap", n, (g == 1 ? TBTC_GAP_LONG_US : TBTC_GAP_SHORT_US) * TBTC_CLK_MHZ);
      chk("start", driver_seq_start, 32'h1);
    end
    apb(1'b1, TST, 32'h00000000);
    tick(1);
    chk("pat stop", {driver_seq_busy, selftest_continuous}, 32'h0);
  endtask
  task t_reset;
    apb(1'b1, 12'h070, 32'h0000FFFF);
    chk("unmap wr", rerr, 32'h1);
    rd("unmap rd", 12'h070, 32'h00000000);
    apb(1'b1, TST, 32'h00000008);
    soft_rst <= 1'b1;
    tick(1);
    soft_rst <= 1'b0;
    rd("soft test", TST, 32'h00000008);
    rd("soft sts", STS, 32'h00000801);
    chk("mapped ok", rerr, 32'h0);
    nrst <= 1'b0;
    tick(2);
    nrst <= 1'b1;
    tick(1);
    rd("hard test", TST, 32'h00000000);
    rd("hard sts", STS, 32'h00000804);
  endtask
  initial begin
    {nrst, soft_rst, psel, penable, pwrite, paddr, pwdata} = '0;
    {basic_ctrl_loopback, mac_side_link_force, speed_100, full_duplex, signal_detect_config} = '0;
    {pol_invert_detect, phy_status_read, selftest_active, selftest_restart, selftest_nibble_err} = '0;
    pstrb = 4'h3;
    n_mismatch = 0;
    n_tests = 0;
    tick(12);
    nrst <= 1'b1;
    tick(1);
    t_defaults();
    t_ctrl();
    t_pol();
    t_err();
    t_test();
    t_reset();
    wrap_up();
  end
  initial begin
    #800000;
    n_mismatch++;
    wrap_up();
  end
endmodule

// File: verification/tbtc_tx_model.sv
/*
  tbtc_tx_model: stand-in for the 10 Mb transmitter that ends each test sequence.
  assumes driver_seq_start is a one-cycle pulse on clk.
*/
`timescale 1ns/10ps
module tbtc_tx_model #(
  parameter int SEQ_CYC = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // sequencer side
  input wire logic driver_seq_start,
  output logic test_seq_done
);
  // ****************************************
  // sequence length counter
  // ****************************************
  int cnt_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= 0;
      test_seq_done <= 1'b0;
    end else begin
      test_seq_done <= (cnt_ff == 1);
      if (driver_seq_start) begin
        cnt_ff <= SEQ_CYC;
      end else if (cnt_ff != 0) begin
        cnt_ff <= cnt_ff - 1;
      end
    end
  end
endmodule

// File: verilog/tbtc_err_cnt.sv
/*
  tbtc_err_cnt: saturating count of errored nibbles during self test.
  assumes restart and nibble_err are single-cycle pulses on clk.
*/
`timescale 1ns/10ps
module tbtc_err_cnt
  import tbtc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // counter signals
  tbtc_test_if.errc tif
);

  logic [7:0] cnt_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= TBTC_ERR_RST;
    end else if (tif.restart) begin
      cnt_ff <= TBTC_ERR_RST;
    end else if (tif.nibble_err && (cnt_ff != TBTC_ERR_MAX)) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  assign tif.err_count = cnt_ff;

endmodule

// File: verilog/tbtc_patt_gen.sv
/*
  tbtc_patt_gen: sequences 10 Mb driver test patterns with a gap timer.
  assumes the transmitter pulses seq_done when a sequence ends.
*/
`timescale 1ns/10ps
module tbtc_patt_gen
  import tbtc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic soft_rst,
  // pattern signals
  tbtc_test_if.patt tif
);

  typedef enum logic [1:0] {TBTC_PG_IDLE, TBTC_PG_SEND, TBTC_PG_GAP} tbtc_pg_t;
  tbtc_pg_t state_ff;
  logic [TBTC_GAP_W-1:0] gap_ff;
  logic start_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= TBTC_PG_IDLE;
      gap_ff <= '0;
      start_ff <= 1'b0;
    end else if (soft_rst || !tif.pat_en) begin
      state_ff <= TBTC_PG_IDLE;
      gap_ff <= '0;
      start_ff <= 1'b0;
    end else begin
      start_ff <= 1'b0;
      unique case (state_ff)
        TBTC_PG_IDLE: begin
          state_ff <= TBTC_PG_SEND;
          start_ff <= 1'b1;
        end
        TBTC_PG_SEND: begin
          if (tif.seq_done) begin
            state_ff <= TBTC_PG_GAP;
            gap_ff <= (tif.gap_long ? TBTC_GAP_LONG_CYC : TBTC_GAP_SHORT_CYC) - TBTC_GAP_ONE;
          end
        end
        TBTC_PG_GAP: begin
          if (gap_ff == '0) begin
            state_ff <= TBTC_PG_SEND;
            start_ff <= 1'b1;
          end else begin
            gap_ff <= gap_ff - TBTC_GAP_ONE;
          end
        end
      endcase
    end
  end

  assign tif.seq_start = start_ff;
  assign tif.seq_busy = (state_ff == TBTC_PG_SEND);

endmodule

// File: verilog/tbtc_regs.sv
/*
  tbtc_regs: 10BASE-T control/status and driver test/self test
  extension registers behind an APB slave.
  assumes status inputs come from logic on clk, except the MAC side
  link force pin which is synchronised here.
*/
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
module tbtc_regs
  import tbtc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic soft_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link and mode status
  input wire logic basic_ctrl_loopback,
  input wire logic mac_side_link_force,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic signal_detect_config,
  input wire logic pol_invert_detect,
  input wire logic phy_status_read,
  // self test status
  input wire logic selftest_active,
  input wire logic selftest_restart,
  input wire logic selftest_nibble_err,
  input wire logic test_seq_done,
  // 10BASE-T controls
  output logic [2:0] squelch_sel,
  output logic ten_mb_loop_disable,
  output logic link_pulse_tx_en,
  output logic link_good_forced,
  output logic force_inverted_pol,
  output logic auto_pol_correct_en,
  output logic polarity_status,
  output logic [1:0] silence_thresh_sel,
  output logic heartbeat_en,
  output logic jabber_en,
  // driver test and self test controls
  output logic mii_clk_force,
  output logic selftest_continuous,
  output logic driver_pattern_enable,
  output logic [1:0] driver_pattern_select,
  output logic driver_seq_start,
  output logic driver_seq_busy,
  output logic mgmt_data_pullup_en
);

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [2:0] rsv_hi_ff;
  logic [2:0] squelch_ff;
  logic loop_dis_ff;
  logic link_pulse_disable_ff;
  logic link_frc_ff;
  logic pol_frc_ff;
  logic pol_sts_ff;
  logic apol_dis_ff;
  logic sil_msb_ff;
  logic hb_dis_ff;
  logic jab_dis_ff;
  logic rsv7_ff;
  logic mii_clk_ff;
  logic cont_ff;
  logic pat_en_ff;
  logic pullup_ff;
  logic gap_ff;
  logic [1:0] pat_sel_ff;
  logic [31:0] rdata_ff;
  logic rd_pol_ff;
  logic link_sync1_ff;
  logic link_sync2_ff;
  logic nxt_pol_sts;
  logic [15:0] sts_ctrl_word;
  logic [15:0] test_ext_word;

  tbtc_test_if tif ();

  // ****************************************************************
  // apb decode
  // ****************************************************************
  logic setup_ph;
  logic access_ph;
  logic hit_sts;
  logic hit_test;
  logic wr_sts;
  logic wr_test;
  logic rd_sts;

  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign hit_sts = (paddr == TBTC_ADDR_STS_CTRL);
  assign hit_test = (paddr == TBTC_ADDR_TEST_EXT);
  assign wr_sts = access_ph && pwrite && hit_sts;
  assign wr_test = access_ph && pwrite && hit_test;
  assign rd_sts = access_ph && !pwrite && hit_sts;
  assign pready = 1'b1;
  assign pslverr = access_ph && !(hit_sts || hit_test);

  // ****************************************************************
  // read words
  // ****************************************************************
  // top bit reads zero
  assign sts_ctrl_word[TBTC_B_RSV_TOP] = 1'b0;
  assign sts_ctrl_word[TBTC_B_RSV_HI:TBTC_B_RSV_LO] = rsv_hi_ff;
  assign sts_ctrl_word[TBTC_B_SQ_HI:TBTC_B_SQ_LO] = squelch_ff;
  assign sts_ctrl_word[TBTC_B_LOOP_DIS] = loop_dis_ff;
  assign sts_ctrl_word[TBTC_B_LINK_PULSE_DISABLE] = link_pulse_disable_ff;
  assign sts_ctrl_word[TBTC_B_LINK_FRC] = link_frc_ff;
  assign sts_ctrl_word[TBTC_B_POL_FRC] = pol_frc_ff;
  assign sts_ctrl_word[TBTC_B_POL_STS] = pol_sts_ff;
  assign sts_ctrl_word[TBTC_B_APOL_DIS] = apol_dis_ff;
  assign sts_ctrl_word[TBTC_B_SIL_MSB] = sil_msb_ff;
  assign sts_ctrl_word[TBTC_B_HB_DIS] = hb_dis_ff;
  assign sts_ctrl_word[TBTC_B_JAB_DIS] = jab_dis_ff;

  assign test_ext_word[TBTC_B_ERR_HI:TBTC_B_ERR_LO] = tif.err_count;
  assign test_ext_word[TBTC_B_RSV7] = rsv7_ff;
  assign test_ext_word[TBTC_B_MII_CLK] = mii_clk_ff;
  assign test_ext_word[TBTC_B_CONT] = cont_ff;
  assign test_ext_word[TBTC_B_PAT_EN] = pat_en_ff;
  assign test_ext_word[TBTC_B_PULLUP] = pullup_ff;
  assign test_ext_word[TBTC_B_GAP] = gap_ff;
  assign test_ext_word[TBTC_B_PSEL_HI:TBTC_B_PSEL_LO] = pat_sel_ff;

  // read data captured in setup, shown in access
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= '0;
      rd_pol_ff <= 1'b0;
    end else if (setup_ph && !pwrite) begin
      rdata_ff <= hit_sts ? {16'h0000, sts_ctrl_word} : (hit_test ? {16'h0000, test_ext_word} : 32'h0000_0000);
      rd_pol_ff <= hit_sts && pol_sts_ff;
    end
  end

  assign prdata = rdata_ff;

  // ****************************************************************
  // 10BASE-T control writes, low byte
  // ****************************************************************
  // hard reset defaults
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      link_pulse_disable_ff <= 1'b0;
      link_frc_ff <= 1'b0;
      pol_frc_ff <= 1'b0;
      apol_dis_ff <= 1'b0;
      sil_msb_ff <= TBTC_RST_SIL_MSB;
      hb_dis_ff <= 1'b0;
      jab_dis_ff <= 1'b0;
    end else if (wr_sts && pstrb[0]) begin
      link_pulse_disable_ff <= pwdata[TBTC_B_LINK_PULSE_DISABLE];
      link_frc_ff <= pwdata[TBTC_B_LINK_FRC];
      pol_frc_ff <= pwdata[TBTC_B_POL_FRC];
      apol_dis_ff <= pwdata[TBTC_B_APOL_DIS];
      sil_msb_ff <= pwdata[TBTC_B_SIL_MSB];
      hb_dis_ff <= pwdata[TBTC_B_HB_DIS];
      jab_dis_ff <= pwdata[TBTC_B_JAB_DIS];
    end
  end

  // ****************************************************************
  // 10BASE-T control writes, high byte
  // ****************************************************************
  // squelch field store
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rsv_hi_ff <= TBTC_RST_RSV;
      squelch_ff <= TBTC_RST_SQ;
      loop_dis_ff <= 1'b0;
    end else if (wr_sts && pstrb[1]) begin
      rsv_hi_ff <= pwdata[TBTC_B_RSV_HI:TBTC_B_RSV_LO];
      squelch_ff <= pwdata[TBTC_B_SQ_HI:TBTC_B_SQ_LO];
      loop_dis_ff <= pwdata[TBTC_B_LOOP_DIS];
    end
  end

  // ****************************************************************
  // polarity latch
  // ****************************************************************
  // latch high, read clears
  always_comb begin
    nxt_pol_sts = pol_sts_ff;
    if ((rd_sts && rd_pol_ff) || phy_status_read) begin
      nxt_pol_sts = 1'b0;
    end
    if (pol_invert_detect) begin
      nxt_pol_sts = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pol_sts_ff <= 1'b0;
    end else begin
      pol_sts_ff <= nxt_pol_sts;
    end
  end

  // ****************************************************************
  // driver test and self test writes
  // ****************************************************************
  // hard reset only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rsv7_ff <= 1'b0;
      mii_clk_ff <= 1'b0;
      cont_ff <= 1'b0;
      pat_en_ff <= 1'b0;
      pullup_ff <= 1'b0;
      gap_ff <= 1'b0;
      pat_sel_ff <= TBTC_PAT_DATA_EOP0;
    end else if (wr_test && pstrb[0]) begin
      rsv7_ff <= pwdata[TBTC_B_RSV7];
      mii_clk_ff <= pwdata[TBTC_B_MII_CLK];
      cont_ff <= pwdata[TBTC_B_CONT];
      pat_en_ff <= pwdata[TBTC_B_PAT_EN];
      pullup_ff <= pwdata[TBTC_B_PULLUP];
      gap_ff <= pwdata[TBTC_B_GAP];
      pat_sel_ff <= pwdata[TBTC_B_PSEL_HI:TBTC_B_PSEL_LO];
    end
  end

  // ****************************************************************
  // mac side link force synchroniser
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      link_sync1_ff <= 1'b0;
      link_sync2_ff <= 1'b0;
    end else begin
      link_sync1_ff <= mac_side_link_force;
      link_sync2_ff <= link_sync1_ff;
    end
  end

  // ****************************************************************
  // 10BASE-T control outputs
  // ****************************************************************
  assign squelch_sel = squelch_ff;
  assign ten_mb_loop_disable = loop_dis_ff | basic_ctrl_loopback;
  assign link_pulse_tx_en = !link_pulse_disable_ff;
  assign link_good_forced = link_frc_ff | link_sync2_ff;
  assign force_inverted_pol = pol_frc_ff && !speed_100;
  assign auto_pol_correct_en = !apol_dis_ff;
  assign polarity_status = pol_sts_ff;
  assign silence_thresh_sel = {sil_msb_ff, signal_detect_config};
  assign heartbeat_en = !speed_100 && !full_duplex && !hb_dis_ff;
  assign jabber_en = speed_100 || !jab_dis_ff;

  // ****************************************************************
  // driver test and self test outputs
  // ****************************************************************
  // force MII clocks
  assign mii_clk_force = mii_clk_ff;
  assign selftest_continuous = cont_ff && selftest_active;
  assign mgmt_data_pullup_en = pullup_ff;

  assign tif.pat_en = pat_en_ff;
  assign tif.pat_sel = pat_sel_ff;
  assign tif.gap_long = gap_ff;
  assign tif.seq_done = test_seq_done;
  assign tif.restart = selftest_restart;
  assign tif.nibble_err = selftest_nibble_err;
  assign driver_pattern_enable = pat_en_ff;
  assign driver_pattern_select = pat_en_ff ? pat_sel_ff : TBTC_PAT_DATA_EOP0;
  assign driver_seq_start = tif.seq_start;
  assign driver_seq_busy = tif.seq_busy;

  // ****************************************************************
  // helpers
  // ****************************************************************
  tbtc_patt_gen u_patt (
    .clk(clk),
    .nrst(nrst),
    .soft_rst(soft_rst),
    .tif(tif.patt)
  );

  tbtc_err_cnt u_errc (
    .clk(clk),
    .nrst(nrst),
    .tif(tif.errc)
  );

endmodule
